//--- rtl/sdc_pkg.sv
// Purpose: shared constants and types for the signal path configuration word
// Assumes: a 16-bit word held in non-volatile cell 005h of a 32-cell space
// Notes:   coefficients are unsigned Q1.15, gain is in tenths
package sdc_pkg;

  localparam int          CELL_AW          = 5;
  localparam int          WORD_W           = 16;
  localparam logic [4:0]  CFG_CELL         = 5'h05;
  localparam logic [15:0] ERASED_WORD      = 16'h0000;
  // power-up contents of the cell; plain default
  localparam logic [15:0] CFG_RESET        = 16'h0000;

  // field positions
  localparam int IIR_LSB        = 0;
  localparam int IIR_MSB        = 2;
  localparam int SENSOR_PTC_BIT = 3;
  localparam int PWM_SEL_LSB    = 4;
  localparam int PWM_SEL_MSB    = 5;
  localparam int DUAL_IR_BIT    = 6;
  localparam int SLOPE_SIGN_BIT = 7;
  localparam int FIR_LSB        = 8;
  localparam int FIR_MSB        = 10;
  localparam int GAIN_LSB       = 11;
  localparam int GAIN_MSB       = 13;
  localparam int SHOCK_SIGN_BIT = 15;

  // iir coefficient codes and values
  localparam logic [2:0]  IIR_CODE_571     = 3'h7;
  localparam logic [2:0]  IIR_CODE_666     = 3'h6;
  localparam logic [2:0]  IIR_CODE_800     = 3'h5;
  localparam logic [2:0]  IIR_CODE_BYPASS  = 3'h4;
  localparam logic [15:0] COEF_HALF        = 16'h4000;
  localparam logic [15:0] COEF_0571        = 16'h4925;
  localparam logic [15:0] COEF_0429        = 16'h36DB;
  localparam logic [15:0] COEF_0667        = 16'h5555;
  localparam logic [15:0] COEF_0333        = 16'h2AAB;
  localparam logic [15:0] COEF_0800        = 16'h6666;
  localparam logic [15:0] COEF_0200        = 16'h199A;
  localparam logic [15:0] COEF_ONE         = 16'h8000;
  localparam logic [15:0] COEF_ZERO        = 16'h0000;

  // fir length is 8 shifted left by the code
  localparam logic [10:0] FIR_BASE_LEN     = 11'h008;

  // gain in tenths
  localparam logic [9:0]  GAIN_X1          = 10'h00A;
  localparam logic [9:0]  GAIN_X3          = 10'h01E;
  localparam logic [9:0]  GAIN_X6          = 10'h03C;
  localparam logic [9:0]  GAIN_X12_5       = 10'h07D;
  localparam logic [9:0]  GAIN_X25         = 10'h0FA;
  localparam logic [9:0]  GAIN_X50         = 10'h1F4;
  localparam logic [9:0]  GAIN_X100        = 10'h3E8;

  // pwm selection codes
  localparam logic [1:0]  PWM_AMB_IR1      = 2'h0;
  localparam logic [1:0]  PWM_AMB_IR2      = 2'h1;
  localparam logic [1:0]  PWM_IR2_ONLY     = 2'h2;
  localparam logic [1:0]  PWM_IR1_IR2      = 2'h3;

  typedef enum logic [1:0] {
    SDC_Q_AMBIENT,
    SDC_Q_IR_ONE,
    SDC_Q_IR_TWO,
    SDC_Q_UNDEFINED
  } sdc_quantity_t;

endpackage

//--- rtl/sdc_cfg_decode.sv
// Purpose: combinational decode of the configuration word into settings
// Assumes: caller registers every result
// Notes:   no state here
`timescale 1ns/1ps
module sdc_cfg_decode (
  input  wire logic [15:0]          cfg_i,
  output logic      [15:0]          feedback_coef_o,
  output logic      [15:0]          input_coef_o,
  output logic                      iir_bypass_o,
  output sdc_pkg::sdc_quantity_t    pwm_first_o,
  output sdc_pkg::sdc_quantity_t    pwm_second_o,
  output logic                      second_valid_o,
  output logic      [10:0]          fir_length_o,
  output logic      [9:0]           gain_o,
  output logic                      preamp_bypass_o
);

  logic [2:0] iir_code;
  logic [1:0] pwm_code;
  logic [2:0] fir_code;
  logic [2:0] gain_code;

  assign iir_code  = cfg_i[sdc_pkg::IIR_MSB:sdc_pkg::IIR_LSB];
  assign pwm_code  = cfg_i[sdc_pkg::PWM_SEL_MSB:sdc_pkg::PWM_SEL_LSB];
  assign fir_code  = cfg_i[sdc_pkg::FIR_MSB:sdc_pkg::FIR_LSB];
  assign gain_code = cfg_i[sdc_pkg::GAIN_MSB:sdc_pkg::GAIN_LSB];

  always_comb begin
    // top bit clear means half and half regardless of low bits
    feedback_coef_o = sdc_pkg::COEF_HALF;
    input_coef_o    = sdc_pkg::COEF_HALF;
    iir_bypass_o    = 1'b0;
    case (iir_code)
      sdc_pkg::IIR_CODE_571: begin
        feedback_coef_o = sdc_pkg::COEF_0571;
        input_coef_o    = sdc_pkg::COEF_0429;
      end
      sdc_pkg::IIR_CODE_666: begin
        feedback_coef_o = sdc_pkg::COEF_0667;
        input_coef_o    = sdc_pkg::COEF_0333;
      end
      sdc_pkg::IIR_CODE_800: begin
        feedback_coef_o = sdc_pkg::COEF_0800;
        input_coef_o    = sdc_pkg::COEF_0200;
      end
      sdc_pkg::IIR_CODE_BYPASS: begin
        feedback_coef_o = sdc_pkg::COEF_ONE;
        input_coef_o    = sdc_pkg::COEF_ZERO;
        iir_bypass_o    = 1'b1;
      end
      default: begin
      end
    endcase
  end

  always_comb begin
    pwm_first_o    = sdc_pkg::SDC_Q_AMBIENT;
    pwm_second_o   = sdc_pkg::SDC_Q_IR_ONE;
    second_valid_o = 1'b1;
    case (pwm_code)
      sdc_pkg::PWM_AMB_IR2: begin
        pwm_second_o = sdc_pkg::SDC_Q_IR_TWO;
      end
      sdc_pkg::PWM_IR1_IR2: begin
        pwm_first_o  = sdc_pkg::SDC_Q_IR_ONE;
        pwm_second_o = sdc_pkg::SDC_Q_IR_TWO;
      end
      sdc_pkg::PWM_IR2_ONLY: begin
        pwm_first_o    = sdc_pkg::SDC_Q_IR_TWO;
        pwm_second_o   = sdc_pkg::SDC_Q_UNDEFINED;
        second_valid_o = 1'b0;
      end
      default: begin
      end
    endcase
  end

  assign fir_length_o = 11'(sdc_pkg::FIR_BASE_LEN << fir_code);

  always_comb begin
    preamp_bypass_o = 1'b0;
    case (gain_code)
      3'h0: begin
        gain_o          = sdc_pkg::GAIN_X1;
        preamp_bypass_o = 1'b1;
      end
      3'h1:    gain_o = sdc_pkg::GAIN_X3;
      3'h2:    gain_o = sdc_pkg::GAIN_X6;
      3'h3:    gain_o = sdc_pkg::GAIN_X12_5;
      3'h4:    gain_o = sdc_pkg::GAIN_X25;
      3'h5:    gain_o = sdc_pkg::GAIN_X50;
      default: gain_o = sdc_pkg::GAIN_X100;
    endcase
  end

endmodule // sdc_cfg_decode

//--- rtl/sdc_config_word.sv
// Purpose: signal path configuration word in cell 005h with decoded settings
// Assumes: cell port driven by serial-interface logic on the same clock
// Notes:   all setting outputs lag the stored word by one clock
`timescale 1ns/1ps
module sdc_config_word (
  input  wire logic                   CLK_I,
  input  wire logic                   RST_N_I,
  input  wire logic [4:0]             CELL_ADDR_I,
  input  wire logic [15:0]            CELL_WDATA_I,
  input  wire logic                   CELL_WR_I,
  input  wire logic                   CELL_RD_I,
  output logic      [15:0]            CELL_RDATA_O,
  output logic                        CELL_RVALID_O,
  output logic                        CELL_WACK_O,
  output logic                        CELL_WREFUSED_O,
  output logic      [15:0]            IIR_FEEDBACK_COEF_O,
  output logic      [15:0]            IIR_INPUT_COEF_O,
  output logic                        IIR_BYPASS_O,
  output logic                        AMBIENT_PTC_O,
  output sdc_pkg::sdc_quantity_t      PWM_FIRST_O,
  output sdc_pkg::sdc_quantity_t      PWM_SECOND_O,
  output logic                        PWM_SECOND_VALID_O,
  output logic                        DUAL_IR_O,
  output logic                        ALPHA_SLOPE_NEGATIVE_O,
  output logic      [10:0]            FIR_LENGTH_O,
  output logic      [9:0]             GAIN_TENTHS_O,
  output logic                        PREAMP_BYPASS_O,
  output logic                        SHOCK_NEGATIVE_O
);

  logic [15:0]            cfg;
  logic                   hit_wr;
  logic                   hit_rd;
  logic                   erase_req;
  logic                   store_ok;
  logic [15:0]            next_feedback;
  logic [15:0]            next_input;
  logic                   next_bypass;
  sdc_pkg::sdc_quantity_t next_first;
  sdc_pkg::sdc_quantity_t next_second;
  logic                   next_second_valid;
  logic [10:0]            next_fir;
  logic [9:0]             next_gain;
  logic                   next_preamp_bypass;

  assign hit_wr    = CELL_WR_I && (CELL_ADDR_I == sdc_pkg::CFG_CELL);
  assign hit_rd    = CELL_RD_I && (CELL_ADDR_I == sdc_pkg::CFG_CELL);
  assign erase_req = CELL_WDATA_I == sdc_pkg::ERASED_WORD;
  // a non-zero value only lands in an erased cell, as the cell cannot rewrite
  assign store_ok  = erase_req || (cfg == sdc_pkg::ERASED_WORD);

  // whole word stored, bit 14 and calibration fields included, so readback matches
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cfg <= sdc_pkg::CFG_RESET;
    end else if (hit_wr && store_ok) begin
      cfg <= CELL_WDATA_I;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      CELL_WACK_O     <= 1'b0;
      CELL_WREFUSED_O <= 1'b0;
    end else begin
      CELL_WACK_O     <= hit_wr && store_ok;
      CELL_WREFUSED_O <= hit_wr && !store_ok;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      CELL_RDATA_O  <= 16'h0000;
      CELL_RVALID_O <= 1'b0;
    end else begin
      CELL_RVALID_O <= hit_rd;
      if (hit_rd) begin
        CELL_RDATA_O <= cfg;
      end
    end
  end

  sdc_cfg_decode u_decode (
    .cfg_i           (cfg),
    .feedback_coef_o (next_feedback),
    .input_coef_o    (next_input),
    .iir_bypass_o    (next_bypass),
    .pwm_first_o     (next_first),
    .pwm_second_o    (next_second),
    .second_valid_o  (next_second_valid),
    .fir_length_o    (next_fir),
    .gain_o          (next_gain),
    .preamp_bypass_o (next_preamp_bypass)
  );

  // bit 14 is never looked at by any setting
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      IIR_FEEDBACK_COEF_O    <= sdc_pkg::COEF_HALF;
      IIR_INPUT_COEF_O       <= sdc_pkg::COEF_HALF;
      IIR_BYPASS_O           <= 1'b0;
      AMBIENT_PTC_O          <= 1'b0;
      PWM_FIRST_O            <= sdc_pkg::SDC_Q_AMBIENT;
      PWM_SECOND_O           <= sdc_pkg::SDC_Q_IR_ONE;
      PWM_SECOND_VALID_O     <= 1'b1;
      DUAL_IR_O              <= 1'b0;
      ALPHA_SLOPE_NEGATIVE_O <= 1'b0;
      FIR_LENGTH_O           <= sdc_pkg::FIR_BASE_LEN;
      GAIN_TENTHS_O          <= sdc_pkg::GAIN_X1;
      PREAMP_BYPASS_O        <= 1'b1;
      SHOCK_NEGATIVE_O       <= 1'b0;
    end else begin
      IIR_FEEDBACK_COEF_O    <= next_feedback;
      IIR_INPUT_COEF_O       <= next_input;
      IIR_BYPASS_O           <= next_bypass;
      AMBIENT_PTC_O          <= cfg[sdc_pkg::SENSOR_PTC_BIT];
      PWM_FIRST_O            <= next_first;
      PWM_SECOND_O           <= next_second;
      PWM_SECOND_VALID_O     <= next_second_valid;
      DUAL_IR_O              <= cfg[sdc_pkg::DUAL_IR_BIT];
      ALPHA_SLOPE_NEGATIVE_O <= cfg[sdc_pkg::SLOPE_SIGN_BIT];
      FIR_LENGTH_O           <= next_fir;
      GAIN_TENTHS_O          <= next_gain;
      PREAMP_BYPASS_O        <= next_preamp_bypass;
      SHOCK_NEGATIVE_O       <= cfg[sdc_pkg::SHOCK_SIGN_BIT];
    end
  end

  iir_half_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !cfg[2] |=> (IIR_FEEDBACK_COEF_O == 16'h4000) && (IIR_INPUT_COEF_O == 16'h4000)
      && !IIR_BYPASS_O)
    else $error("iir coefficients not half with top code bit clear");

  iir_codes_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (cfg[2:0] == 3'h5) |=> (IIR_FEEDBACK_COEF_O == 16'h6666) && (IIR_INPUT_COEF_O == 16'h199A))
    else $error("iir code 101 gave wrong coefficients");

  iir_bypass_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (cfg[2:0] == 3'h4) |=> IIR_BYPASS_O && (IIR_INPUT_COEF_O == 16'h0000))
    else $error("iir bypass not set for code 100");

  sensor_type_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    ##1 AMBIENT_PTC_O == $past(cfg[3]))
    else $error("ambient sensor type does not follow bit 3");

  pwm_pair_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (cfg[5:4] == 2'h2) |=> !PWM_SECOND_VALID_O && (PWM_FIRST_O == sdc_pkg::SDC_Q_IR_TWO))
    else $error("pwm selection 10 decoded wrongly");

  pwm_ir_pair_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (cfg[5:4] == 2'h3) |=> (PWM_FIRST_O == sdc_pkg::SDC_Q_IR_ONE)
      && (PWM_SECOND_O == sdc_pkg::SDC_Q_IR_TWO) && PWM_SECOND_VALID_O)
    else $error("pwm selection 11 decoded wrongly");

  dual_ir_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    ##1 DUAL_IR_O == $past(cfg[6]))
    else $error("sensor count does not follow bit 6");

  fir_len_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (cfg[10:8] == 3'h7) |=> (FIR_LENGTH_O == 11'h400))
    else $error("fir length for code 111 is not 1024");

  gain_top_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (cfg[13:12] == 2'h3) |=> (GAIN_TENTHS_O == 10'h3E8) && !PREAMP_BYPASS_O)
    else $error("gain for codes 110 and 111 is not 100");

  shock_sign_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    ##1 SHOCK_NEGATIVE_O == $past(cfg[15]))
    else $error("shock sign does not follow bit 15");

  read_back_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    hit_rd |=> CELL_RVALID_O && (CELL_RDATA_O == $past(cfg)))
    else $error("read of cell 005h did not return stored word");

  erase_cell_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (hit_wr && erase_req) |=> (cfg == 16'h0000) && CELL_WACK_O)
    else $error("erase write did not clear the cell");

  refuse_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (hit_wr && !erase_req && (cfg != 16'h0000)) |=> CELL_WREFUSED_O && $stable(cfg))
    else $error("write over unerased cell was not refused");

  iir_codes_hi_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (cfg[2:0] == 3'h7) |=> (IIR_FEEDBACK_COEF_O == 16'h4925) && (IIR_INPUT_COEF_O == 16'h36DB))
    else $error("iir code 111 gave wrong coefficients");

  iir_codes_mid_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (cfg[2:0] == 3'h6) |=> (IIR_FEEDBACK_COEF_O == 16'h5555) && (IIR_INPUT_COEF_O == 16'h2AAB))
    else $error("iir code 110 gave wrong coefficients");

  pwm_ambient_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !cfg[5] |=> (PWM_FIRST_O == sdc_pkg::SDC_Q_AMBIENT) && PWM_SECOND_VALID_O
      && (PWM_SECOND_O == ($past(cfg[4]) ? sdc_pkg::SDC_Q_IR_TWO : sdc_pkg::SDC_Q_IR_ONE)))
    else $error("pwm selection with ambient first decoded wrongly");

  fir_follow_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    ##1 FIR_LENGTH_O == 11'(sdc_pkg::FIR_BASE_LEN << $past(cfg[10:8])))
    else $error("fir length does not follow bits 10 to 8");

  gain_mid_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (cfg[13:11] == 3'h3) |=> (GAIN_TENTHS_O == 10'h07D) && !PREAMP_BYPASS_O)
    else $error("gain for code 011 is not 12.5");

  preamp_bypass_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (cfg[13:11] == 3'h0) |=> PREAMP_BYPASS_O && (GAIN_TENTHS_O == 10'h00A))
    else $error("gain code 000 did not bypass the preamplifier");

  write_take_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (hit_wr && store_ok) |=> CELL_WACK_O && !CELL_WREFUSED_O && (cfg == $past(CELL_WDATA_I)))
    else $error("accepted write did not store the word");

  port_idle_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (!hit_wr && !hit_rd) |=> !CELL_WACK_O && !CELL_WREFUSED_O && !CELL_RVALID_O
      && $stable(cfg))
    else $error("cell port answered or changed without a request");

endmodule // sdc_config_word

//--- tb/sdc_master_model.sv
// Purpose: serial master model driving the configuration cell port
// Assumes: same clock as the word block
// Notes:   released lines show the inverse of the last value, never a held copy
`timescale 1ns/1ps
module sdc_master_model #(
  parameter bit EXT_PWM = 1'b0
) (
  input  wire logic        clk_i,
  output logic      [4:0]  addr_o,
  output logic      [15:0] wdata_o,
  output logic             wr_o,
  output logic             rd_o,
  input  wire logic [15:0] rdata_i,
  input  wire logic        rvalid_i,
  input  wire logic        wack_i,
  input  wire logic        wrefused_i
);
  // gain, slope sign and sensor type belong to calibration
  localparam logic [15:0] CAL_MASK = 16'h3888;

  initial begin
    addr_o  = 5'h00;
    wdata_o = 16'h0000;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  task automatic raw_write(input logic [4:0] a, input logic [15:0] d,
                           output logic ack, output logic refused);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    wdata_o <= ~d;
    addr_o  <= ~a;
    #1;
    ack     = wack_i;
    refused = wrefused_i;
  endtask

  task automatic raw_read(input logic [4:0] a, output logic [15:0] d, output logic got);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    addr_o <= ~a;
    #1;
    got = rvalid_i;
    d   = rdata_i;
  endtask

  // read-modify-write that a well-behaved host uses
  task automatic program_word(input logic [15:0] value, output logic ok);
    logic [15:0] old;
    logic [15:0] merged;
    logic        got;
    logic        a1;
    logic        a2;
    logic        r1;
    logic        r2;
    raw_read(5'h05, old, got);
    merged = (value & ~CAL_MASK) | (old & CAL_MASK);
    if (EXT_PWM && merged[5:4] == 2'h2) begin
      merged[5:4] = 2'h0;
    end
    raw_write(5'h05, 16'h0000, a1, r1);
    raw_write(5'h05, merged, a2, r2);
    ok = got & a1 & a2 & ~r1 & ~r2;
  endtask
endmodule // sdc_master_model

//--- tb/testbench.sv
// Purpose: self-checking bench for the configuration word block
// Assumes: master model drives the cell port
// Notes:   settings are checked one clock after the write answer
`timescale 1ns/1ps
module testbench;
  logic                   clk;
  logic                   rst_n;
  logic [4:0]             addr;
  logic [15:0]            wdata;
  logic                   wr;
  logic                   rd;
  logic [15:0]            rdata;
  logic                   rvalid;
  logic                   wack;
  logic                   wref;
  logic [15:0]            fb_coef;
  logic [15:0]            in_coef;
  logic                   iir_byp;
  logic                   positive_coefficient_sensor;
  sdc_pkg::sdc_quantity_t first_q;
  sdc_pkg::sdc_quantity_t second_q;
  logic                   second_ok;
  logic                   dual;
  logic                   slope;
  logic [10:0]            fir_len;
  logic [9:0]             gain;
  logic                   pre_byp;
  logic                   shock;
  int                     miscompares;
  int                     checks_done;

  sdc_config_word dut_u (.CLK_I(clk), .RST_N_I(rst_n), .CELL_ADDR_I(addr),
    .CELL_WDATA_I(wdata), .CELL_WR_I(wr), .CELL_RD_I(rd), .CELL_RDATA_O(rdata),
    .CELL_RVALID_O(rvalid), .CELL_WACK_O(wack), .CELL_WREFUSED_O(wref),
    .IIR_FEEDBACK_COEF_O(fb_coef), .IIR_INPUT_COEF_O(in_coef), .IIR_BYPASS_O(iir_byp),
    .AMBIENT_PTC_O(positive_coefficient_sensor), .PWM_FIRST_O(first_q), .PWM_SECOND_O(second_q),
    .PWM_SECOND_VALID_O(second_ok), .DUAL_IR_O(dual), .ALPHA_SLOPE_NEGATIVE_O(slope),
    .FIR_LENGTH_O(fir_len), .GAIN_TENTHS_O(gain), .PREAMP_BYPASS_O(pre_byp),
    .SHOCK_NEGATIVE_O(shock));

  sdc_master_model #(.EXT_PWM(1'b1)) master_u (.clk_i(clk), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .rdata_i(rdata), .rvalid_i(rvalid),
    .wack_i(wack), .wrefused_i(wref));

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic cmp_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [31:0] exp_coefs(input logic [2:0] c);
    case (c)
      3'h7:    return {sdc_pkg::COEF_0571, sdc_pkg::COEF_0429};
      3'h6:    return {sdc_pkg::COEF_0667, sdc_pkg::COEF_0333};
      3'h5:    return {sdc_pkg::COEF_0800, sdc_pkg::COEF_0200};
      3'h4:    return {sdc_pkg::COEF_ONE, sdc_pkg::COEF_ZERO};
      default: return {sdc_pkg::COEF_HALF, sdc_pkg::COEF_HALF};
    endcase
  endfunction

  function automatic logic [9:0] exp_gain(input logic [2:0] c);
    logic [9:0] tbl [8] = '{10'h00A, 10'h01E, 10'h03C, 10'h07D, 10'h0FA, 10'h1F4,
                            10'h3E8, 10'h3E8};
    return tbl[c];
  endfunction

  // first quantity, second quantity, second defined
  function automatic logic [4:0] exp_pwm(input logic [1:0] s);
    case (s)
      2'h0:    return {sdc_pkg::SDC_Q_AMBIENT, sdc_pkg::SDC_Q_IR_ONE, 1'b1};
      2'h1:    return {sdc_pkg::SDC_Q_AMBIENT, sdc_pkg::SDC_Q_IR_TWO, 1'b1};
      2'h3:    return {sdc_pkg::SDC_Q_IR_ONE, sdc_pkg::SDC_Q_IR_TWO, 1'b1};
      default: return {sdc_pkg::SDC_Q_IR_TWO, sdc_pkg::SDC_Q_UNDEFINED, 1'b0};
    endcase
  endfunction

  task automatic check_settings(input logic [15:0] w);
    logic [31:0] co;
    logic [4:0]  pw;
    co = exp_coefs(w[2:0]);
    pw = exp_pwm(w[5:4]);
    cmp_val("feedback coef", co[31:16], fb_coef);
    cmp_val("input coef", co[15:0], in_coef);
    cmp_val("iir bypass", {15'h0000, w[2:0] == 3'h4}, {15'h0000, iir_byp});
    cmp_val("ptc type", {15'h0000, w[3]}, {15'h0000, positive_coefficient_sensor});
    cmp_val("pwm pair", {11'h000, pw}, {11'h000, first_q, second_q, second_ok});
    cmp_val("dual ir", {15'h0000, w[6]}, {15'h0000, dual});
    cmp_val("slope sign", {15'h0000, w[7]}, {15'h0000, slope});
    cmp_val("fir length", {5'h00, 11'h008 << w[10:8]}, {5'h00, fir_len});
    cmp_val("gain", {6'h00, exp_gain(w[13:11])}, {6'h00, gain});
    cmp_val("preamp bypass", {15'h0000, w[13:11] == 3'h0}, {15'h0000, pre_byp});
    cmp_val("shock sign", {15'h0000, w[15]}, {15'h0000, shock});
  endtask

  task automatic scen_all_codes();
    logic [2:0]  c;
    logic [15:0] w;
    logic [15:0] d;
    logic        a;
    logic        r;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      w = {c[0], c[1], c, c, c[0], c[0], c[1:0], c[0], c};
      master_u.raw_write(5'h05, 16'h0000, a, r);
      cmp_val("erase ack", 16'h0001, {15'h0000, a & ~r});
      master_u.raw_write(5'h05, w, a, r);
      cmp_val("write ack", 16'h0001, {15'h0000, a & ~r});
      @(posedge clk);
      #1;
      check_settings(w);
      master_u.raw_read(5'h05, d, a);
      cmp_val("read word", w, d);
      cmp_val("read valid", 16'h0001, {15'h0000, a});
    end
  endtask

  // word is nonzero here: unerased write and foreign cells must not touch it
  task automatic scen_refuse();
    logic [15:0] d;
    logic        a;
    logic        r;
    master_u.raw_write(5'h05, 16'h1234, a, r);
    cmp_val("refused write", 16'h0001, {15'h0000, r & ~a});
    master_u.raw_write(5'h06, 16'h0000, a, r);
    cmp_val("foreign write", 16'h0000, {15'h0000, a | r});
    master_u.raw_read(5'h06, d, a);
    cmp_val("foreign read", 16'h0000, {15'h0000, a});
    master_u.raw_read(5'h05, d, a);
    cmp_val("kept word", 16'hFFFF, d);
  endtask

  task automatic scen_program();
    logic [15:0] w;
    logic [15:0] d;
    logic        ok;
    w = ((16'h0020 & ~16'h3888) | (16'hFFFF & 16'h3888)) & ~16'h0030;
    master_u.program_word(16'h0020, ok);
    cmp_val("program ok", 16'h0001, {15'h0000, ok});
    @(posedge clk);
    #1;
    check_settings(w);
    master_u.raw_read(5'h05, d, ok);
    cmp_val("calibration kept", w, d);
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    final_report();
  end

  initial begin
    rst_n = 1'b0;
    miscompares = 0;
    checks_done = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    check_settings(16'h0000);
    scen_all_codes();
    scen_refuse();
    scen_program();
    final_report();
  end
endmodule // testbench
